/* design/flash_protect_host.sv */
// file: host controller issuing flash command and protection sequences
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// (R1) unlock cycles put 555 or AAA on low bits; upper bits are don't care
// (R2) plain array reads go out as single read cycles, no prefix
// (R3) autoselect or exceeded-limit status is left by the reset command
// (R4) autoselect fourth cycle is a read; upper data byte ignored
// (R5) device latches data on first rising edge of write strobe or select
// (R6) sector is named by address bits 21 down to 15 only
// (R7) buffer count written is locations minus one, all in one page
// (R8) sector verify read returns 00h unprotected, 01h protected
// (R9) a buffered program never exceeds 37 bus cycles including commit
// (R10) buffer abort sequence clears the buffer and readies the device
// (R11) erase suspend accepted only during sector erase
// (R12) erase resume accepted only while erase suspended
// (R13) query accepted only in read or autoselect mode
// (R14) exact sequences in order; after an error write reset
// (R15) protection sets entered by three cycles ending 40,60,C0,50 or E0
// (R16) protection sets left by 90 then 00, back to read mode
// (R17) protection status on bit zero: low protected, high unprotected
// (R18) password is four 16-bit portions, each programmed by A0 then data
// (R19) password read back as eight byte locations 00 to 07
// (R20) unlock writes 25, 03 at 00, eight bytes, then 29
// (R21) erase-all persistent bits is 80 then 30 at address 00
// (R22) A0 then sector address with 00 sets; dynamic 01 clears
// (R23) freeze set: A0 then 00 sets lock; one read returns it on bit zero
// (R24) acceleration pin held high while setting persistent or dynamic bits
module flash_protect_host
	import flash_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [31:0]      sw_rdata,
	input  wire logic [7:0]  dq_in,
	output flash_pins_t      flash_pins
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [1:0] {m_read, m_autoselect, m_prot_set, m_suspended} dev_mode_t;
	typedef enum logic [1:0] {h_idle, h_issue, h_wait} host_state_t;

	typedef struct packed {
		host_state_t st;
		dev_mode_t   mode;
		logic        erasing;
		op_t         op;
		logic [21:0] addr;
		logic [7:0]  data;
		logic [7:0]  set_code;
		logic [63:0] password;
		logic [5:0]  count;
		logic [5:0]  step;
		logic [5:0]  last;
		logic        busy;
		logic        refused;
		logic        bit0;
		logic [7:0]  rdata;
		logic [63:0] pw_read;
		bus_req_t    req;
		logic        acc;
		logic [31:0] sw_rdata;
	} host_t;

	host_t cur;
	host_t next_cur;

	logic [7:0]  wbuf [0:31];
	logic        eng_done;
	logic [7:0]  eng_rdata;
	flash_pins_t eng_pins;

	// one step of the current sequence: write flag, address, data
	logic        s_wr;
	logic [21:0] s_addr;
	logic [7:0]  s_data;
	logic [21:0] sect_base;
	logic [21:0] page_base;

	// sector base keeps only the sector field
	assign sect_base = {cur.addr[21:sector_lsb], 15'h0000}; // R6
	assign page_base = {cur.addr[21:5], 5'h00};

	// ****************************************************************
	// sequence table
	// ****************************************************************
	always_comb
	begin
		s_wr   = 1'b1;
		s_addr = 22'h000000;
		s_data = 8'h00;
		// unlock pair shared by multi-cycle commands; high bits stay zero
		if (cur.step == 6'd0)
		begin
			s_addr = {10'h000, unlock_addr_a}; // R1
			s_data = unlock_data_a;
		end
		else if (cur.step == 6'd1)
		begin
			s_addr = {10'h000, unlock_addr_b}; // R1
			s_data = unlock_data_b;
		end
		unique case (cur.op)
			op_read:
			begin
				s_wr   = 1'b0; // R2
				s_addr = cur.addr;
			end
			op_reset, op_suspend, op_resume:
			begin
				s_data = (cur.op == op_reset) ? code_reset :
				         (cur.op == op_suspend) ? code_suspend : code_resume;
			end
			op_query:
			begin
				s_addr = {10'h000, query_addr};
				s_data = code_query;
			end
			op_autoselect, op_sect_verify:
			begin
				if (cur.step == 6'd2)
				begin
					s_addr = {10'h000, unlock_addr_a};
					s_data = code_autoselect;
				end
				else if (cur.step == 6'd3)
				begin
					s_wr   = 1'b0; // R4
					s_addr = (cur.op == op_sect_verify) ?
					         (sect_base | 22'h000004) : cur.addr; // R8
				end
			end
			op_program:
			begin
				if (cur.step == 6'd2)
				begin
					s_addr = {10'h000, unlock_addr_a};
					s_data = code_program;
				end
				else if (cur.step == 6'd3)
				begin
					s_addr = cur.addr;
					s_data = cur.data; // R5
				end
			end
			op_wbuf:
			begin
				// bytes loaded from the program address upward inside one page
				if (cur.step == 6'd2)
				begin
					s_addr = sect_base;
					s_data = code_wbuf_load;
				end
				else if (cur.step == 6'd3)
				begin
					s_addr = sect_base;
					s_data = {2'b00, cur.count - 6'd1}; // R7
				end
				else if (cur.step == cur.last)
				begin
					s_addr = sect_base;
					s_data = code_wbuf_commit; // R9
				end
				else if (cur.step > 6'd3)
				begin
					s_addr = page_base | {17'h00000, 5'(cur.addr[4:0] + 5'(cur.step - 6'd4))}; // R7
					s_data = wbuf[5'(cur.step - 6'd4)];
				end
			end
			op_wbuf_abort:
			begin
				if (cur.step == 6'd2)
				begin
					s_addr = {10'h000, unlock_addr_a};
					s_data = code_reset; // R10
				end
			end
			op_sector_erase:
			begin
				if (cur.step == 6'd2 || cur.step == 6'd3)
					s_addr = {10'h000, unlock_addr_a};
				if (cur.step == 6'd2)
					s_data = code_erase_setup;
				else if (cur.step == 6'd3)
					s_data = unlock_data_a;
				else if (cur.step == 6'd4)
				begin
					s_addr = {10'h000, unlock_addr_b};
					s_data = unlock_data_b;
				end
				else if (cur.step == 6'd5)
				begin
					s_addr = sect_base;
					s_data = code_resume;
				end
			end
			op_enter_set:
			begin
				if (cur.step == 6'd2)
				begin
					s_addr = {10'h000, unlock_addr_a};
					s_data = cur.set_code; // R15
				end
			end
			op_exit_set:
				s_data = (cur.step == 6'd0) ? code_exit_a : code_exit_b; // R16
			op_set_write, op_bit_set, op_bit_clear, op_pw_program:
			begin
				// A0 then target address and data
				if (cur.step == 6'd0)
					s_data = code_program;
				else
				begin
					s_addr = (cur.op == op_set_write) ? 22'h000000 :
					         (cur.op == op_pw_program) ? {20'h00000, cur.addr[1:0]} :
					         cur.addr; // R18 R22
					s_data = (cur.op == op_bit_clear) ? code_bit_clear :
					         (cur.op == op_bit_set) ? code_bit_set : cur.data; // R22 R23
				end
			end
			op_erase_all:
			begin
				// the erase code must land at address zero, not on the unlock pattern
				s_addr = 22'h000000; // R21
				s_data = (cur.step == 6'd0) ? code_erase_setup : code_erase_all; // R21
			end
			op_status_read:
			begin
				s_wr   = 1'b0; // R17 R23
				s_addr = cur.addr;
			end
			op_pw_read:
			begin
				s_wr   = 1'b0;
				s_addr = {16'h0000, cur.step}; // R19
			end
			op_pw_unlock:
			begin
				s_addr = 22'h000000; // R20
				if (cur.step == 6'd0)
					s_data = code_pw_unlock_a;
				else if (cur.step == 6'd1)
					s_data = code_pw_unlock_b;
				else if (cur.step == cur.last)
					s_data = code_wbuf_commit; // R20
				else
				begin
					s_addr = {19'h00000, 3'(cur.step - 6'd2)};
					s_data = cur.password[8 * 3'(cur.step - 6'd2) +: 8]; // R20
				end
			end
			default:
				s_wr = 1'b1;
		endcase
	end

	// ****************************************************************
	// sequencer and software registers
	// ****************************************************************
	always_comb
	begin
		next_cur = cur;
		next_cur.req.valid = 1'b0;
		next_cur.sw_rdata = 32'h00000000;
		if (sw_rd)
		begin
			unique case (sw_addr)
				reg_cmd:    next_cur.sw_rdata = {27'h0000000, cur.op};
				reg_addr:   next_cur.sw_rdata = {10'h000, cur.addr};
				reg_data:   next_cur.sw_rdata = {24'h000000, cur.data};
				reg_status: next_cur.sw_rdata = {24'h000000, cur.erasing, cur.mode,
				                                 cur.acc, cur.bit0, cur.refused, 1'b0, cur.busy};
				reg_rdata:  next_cur.sw_rdata = {24'h000000, cur.rdata};
				reg_pw_lo:  next_cur.sw_rdata = cur.pw_read[31:0];
				reg_pw_hi:  next_cur.sw_rdata = cur.pw_read[63:32];
				reg_count:  next_cur.sw_rdata = {26'h0000000, cur.count};
				default:    next_cur.sw_rdata = 32'h00000000;
			endcase
		end
		if (sw_wr && !cur.busy)
		begin
			unique case (sw_addr)
				reg_addr:  next_cur.addr = sw_wdata[21:0];
				reg_data:  next_cur.data = sw_wdata[7:0];
				reg_pw_lo: next_cur.password[31:0] = sw_wdata;
				reg_pw_hi: next_cur.password[63:32] = sw_wdata;
				reg_count: next_cur.count = (sw_wdata[5:0] > max_wbuf_bytes || sw_wdata[5:0] == 6'd0) ?
				                            max_wbuf_bytes : sw_wdata[5:0]; // R9
				reg_cmd:
				begin
					next_cur.op = op_t'(sw_wdata[4:0]);
					next_cur.set_code = sw_wdata[15:8];
					next_cur.step = 6'd0;
					next_cur.refused = 1'b0;
					next_cur.busy = 1'b1;
					next_cur.st = h_issue;
				end
				default: next_cur.busy = cur.busy;
			endcase
		end
		unique case (cur.st)
			h_idle: next_cur.acc = 1'b0;
			h_issue:
			begin
				// commands the device would ignore are refused here instead
				if ((cur.op == op_suspend && !cur.erasing) || // R11
				    (cur.op == op_resume && cur.mode != m_suspended) || // R12
				    (cur.op == op_query && cur.mode != m_read && cur.mode != m_autoselect)) // R13
				begin
					next_cur.refused = 1'b1;
					next_cur.busy = 1'b0;
					next_cur.st = h_idle;
				end
				else
				begin
					unique case (cur.op)
						op_read, op_reset, op_suspend, op_resume, op_query, op_status_read:
							next_cur.last = 6'd0;
						op_exit_set, op_set_write, op_bit_set, op_bit_clear, op_erase_all,
						op_pw_program:
							next_cur.last = 6'd1;
						op_enter_set, op_wbuf_abort: next_cur.last = 6'd2;
						op_autoselect, op_sect_verify, op_program: next_cur.last = 6'd3;
						op_sector_erase: next_cur.last = 6'd5;
						op_pw_read: next_cur.last = 6'(pw_bytes - 4'd1);
						op_pw_unlock: next_cur.last = 6'(pw_bytes + 4'd2);
						op_wbuf: next_cur.last = cur.count + 6'd4;
						default: next_cur.last = 6'd0;
					endcase
					next_cur.acc = (cur.op == op_bit_set || cur.op == op_bit_clear); // R24
					next_cur.req.valid = 1'b1;
					next_cur.req.write = s_wr;
					next_cur.req.addr  = s_addr;
					next_cur.req.data  = s_data;
					next_cur.st = h_wait;
				end
			end
			h_wait:
			begin
				if (eng_done)
				begin
					if (!s_wr)
					begin
						next_cur.rdata = eng_rdata;
						next_cur.bit0  = eng_rdata[0]; // R17
						if (cur.op == op_pw_read)
							next_cur.pw_read[8 * cur.step[2:0] +: 8] = eng_rdata;
					end
					if (cur.step == cur.last)
					begin
						next_cur.busy = 1'b0;
						next_cur.st = h_idle;
						// track the device mode the finished sequence leaves behind
						unique case (cur.op)
							op_reset: next_cur.mode = cur.erasing ? m_suspended : m_read; // R3 R14
							op_autoselect, op_sect_verify: next_cur.mode = m_autoselect;
							op_enter_set: next_cur.mode = m_prot_set;
							op_exit_set: next_cur.mode = cur.erasing ? m_suspended : m_read; // R16
							op_sector_erase: next_cur.erasing = 1'b1;
							op_suspend: next_cur.mode = m_suspended;
							op_resume: next_cur.mode = m_read;
							default: next_cur.mode = cur.mode;
						endcase
					end
					else
					begin
						next_cur.step = cur.step + 6'd1;
						next_cur.st = h_issue;
					end
				end
			end
			default: next_cur.st = h_idle;
		endcase
	end

	// ****************************************************************
	// write buffer staging and registers
	// ****************************************************************
	always_ff @(posedge mclk)
	begin
		// eight words of four bytes fill the whole 32-byte buffer
		if (sw_wr && !cur.busy && sw_addr >= reg_wbuf)
			for (int i = 0; i < 4; i++)
				wbuf[{sw_addr[2:0], 2'(i)}] <= sw_wdata[8 * i +: 8];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur <= '0;
			cur.count <= max_wbuf_bytes;
		end
		else
			cur <= next_cur;
	end

	flash_cycle_engine engine (
		.mclk  (mclk),
		.rst_n (rst_n),
		.req   (cur.req),
		.dq_in (dq_in),
		.pins  (eng_pins),
		.done  (eng_done),
		.rdata (eng_rdata)
	);

	// acceleration pin registered beside the engine's pin flops
	always_comb
	begin
		flash_pins = eng_pins;
		flash_pins.acc = cur.acc;
	end

	assign sw_rdata = cur.sw_rdata;

endmodule

/* pkg/flash_cmd_pkg.sv */
// package: command codes, pin bundles and timing for the flash protection command host
package flash_cmd_pkg;

	// unlock addresses (byte mode), compared on the low twelve bits only
	localparam logic [11:0] unlock_addr_a = 12'haaa;
	localparam logic [11:0] unlock_addr_b = 12'h555;
	localparam logic [7:0] unlock_data_a = 8'haa;
	localparam logic [7:0] unlock_data_b = 8'h55;

	// command data codes
	localparam logic [7:0] code_reset       = 8'hf0;
	localparam logic [7:0] code_autoselect  = 8'h90;
	localparam logic [7:0] code_program     = 8'ha0;
	localparam logic [7:0] code_wbuf_load   = 8'h25;
	localparam logic [7:0] code_wbuf_commit = 8'h29;
	localparam logic [7:0] code_suspend     = 8'hb0;
	localparam logic [7:0] code_resume      = 8'h30;
	localparam logic [7:0] code_query       = 8'h98;
	localparam logic [11:0] query_addr      = 12'h0aa;
	localparam logic [7:0] code_erase_setup = 8'h80;
	localparam logic [7:0] code_erase_all   = 8'h30;
	localparam logic [7:0] code_exit_a      = 8'h90;
	localparam logic [7:0] code_exit_b      = 8'h00;
	localparam logic [7:0] code_pw_unlock_a = 8'h25;
	localparam logic [7:0] code_pw_unlock_b = 8'h03;
	localparam logic [7:0] code_bit_set     = 8'h00;
	localparam logic [7:0] code_bit_clear   = 8'h01;

	// protection command set selectors (third entry cycle)
	localparam logic [7:0] set_lock_reg   = 8'h40;
	localparam logic [7:0] set_password   = 8'h60;
	localparam logic [7:0] set_persistent = 8'hc0;
	localparam logic [7:0] set_freeze     = 8'h50;
	localparam logic [7:0] set_dynamic    = 8'he0;

	// limits
	localparam int          max_wbuf_cycles  = 37;
	localparam logic [5:0]  max_wbuf_bytes   = 6'd32;
	localparam int          sector_lsb       = 15;
	localparam logic [3:0]  pw_bytes         = 4'd8;
	localparam logic [7:0]  sect_protected_v = 8'h01;

	// bus timing at 125 MHz: write pulse, read access, recovery
	localparam int clk_mhz       = 125;
	localparam int t_wp_ns       = 35;
	localparam int t_acc_ns      = 90;
	localparam int t_rec_ns      = 20;
	localparam logic [4:0] wp_cyc  = 5'((t_wp_ns * clk_mhz + 999) / 1000);
	localparam logic [4:0] acc_cyc = 5'((t_acc_ns * clk_mhz + 999) / 1000);
	localparam logic [4:0] rec_cyc = 5'((t_rec_ns * clk_mhz + 999) / 1000);

	// software register offsets
	localparam logic [3:0] reg_cmd    = 4'h0;
	localparam logic [3:0] reg_addr   = 4'h1;
	localparam logic [3:0] reg_data   = 4'h2;
	localparam logic [3:0] reg_status = 4'h3;
	localparam logic [3:0] reg_rdata  = 4'h4;
	localparam logic [3:0] reg_pw_lo  = 4'h5;
	localparam logic [3:0] reg_pw_hi  = 4'h6;
	localparam logic [3:0] reg_count  = 4'h7;
	localparam logic [3:0] reg_wbuf   = 4'h8;

	// operation codes written to reg_cmd
	typedef enum logic [4:0] {
		op_read, op_reset, op_autoselect, op_sect_verify, op_program,
		op_wbuf, op_wbuf_abort, op_suspend, op_resume, op_query,
		op_enter_set, op_exit_set, op_set_write, op_bit_set, op_bit_clear,
		op_erase_all, op_status_read, op_pw_program, op_pw_read, op_pw_unlock,
		op_sector_erase
	} op_t;

	// device pins driven by the host
	typedef struct packed {
		logic [21:0] addr;
		logic [7:0]  dq_out;
		logic        dq_oe;
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic        acc;
	} flash_pins_t;

	// one bus cycle request to the cycle engine
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [21:0] addr;
		logic [7:0]  data;
	} bus_req_t;

endpackage

/* design/flash_cycle_engine.sv */
// file: single asynchronous flash bus cycle generator
`timescale 1ns/100ps
module flash_cycle_engine
	import flash_cmd_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     rst_n,
	input  wire bus_req_t req,
	input  wire logic [7:0] dq_in,
	output flash_pins_t   pins,
	output logic          done,
	output logic [7:0]    rdata
);

	typedef enum logic [1:0] {e_idle, e_strobe, e_recover} eng_state_t;

	typedef struct packed {
		eng_state_t  st;
		logic [4:0]  cnt;
		flash_pins_t pins;
		logic        done;
		logic [7:0]  rdata;
	} eng_t;

	eng_t cur;
	eng_t next_cur;

	// ce and we fall together and rise together, so data latches on their shared edge
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		unique case (cur.st)
			e_idle:
			begin
				if (req.valid)
				begin
					next_cur.pins.addr   = req.addr;
					next_cur.pins.dq_out = req.data;
					next_cur.pins.dq_oe  = req.write;
					next_cur.pins.ce_n   = 1'b0;
					next_cur.pins.we_n   = ~req.write;
					next_cur.pins.oe_n   = req.write;
					next_cur.cnt = req.write ? wp_cyc : acc_cyc;
					next_cur.st  = e_strobe;
				end
			end
			e_strobe:
			begin
				if (cur.cnt <= 5'd1)
				begin
					if (!cur.pins.oe_n)
						next_cur.rdata = dq_in;
					next_cur.pins.ce_n = 1'b1;
					next_cur.pins.we_n = 1'b1;
					next_cur.pins.oe_n = 1'b1;
					next_cur.cnt = rec_cyc;
					next_cur.st  = e_recover;
				end
				else
					next_cur.cnt = cur.cnt - 5'd1;
			end
			e_recover:
			begin
				// data held past the rising edge for hold time, then released
				next_cur.pins.dq_oe = 1'b0;
				if (cur.cnt <= 5'd1)
				begin
					next_cur.done = 1'b1;
					next_cur.st   = e_idle;
				end
				else
					next_cur.cnt = cur.cnt - 5'd1;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur <= '0;
			cur.st <= e_idle;
			cur.pins.ce_n <= 1'b1;
			cur.pins.we_n <= 1'b1;
			cur.pins.oe_n <= 1'b1;
		end
		else
			cur <= next_cur;
	end

	assign pins  = cur.pins;
	assign done  = cur.done;
	assign rdata = cur.rdata;

endmodule

/* verif/flash_host_props.sv */
// checker: port assertions for the flash protection host
`timescale 1ns/100ps
module flash_host_props
	import flash_cmd_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [3:0]  sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic        sw_wr,
	input wire logic        sw_rd,
	input wire logic [31:0] sw_rdata,
	input wire logic [7:0]  dq_in,
	input wire flash_pins_t flash_pins
);
	logic we;
	logic oe;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// active-high views of the strobes, gated by select
	assign we = !flash_pins.we_n && !flash_pins.ce_n;
	assign oe = !flash_pins.oe_n && !flash_pins.ce_n;
	// ****
	// bus cycle shape and register read data slot
	// ****
	a_write_pulse: assert property ($rose(we) |-> we[*5] ##1 !we)
		else $error("write strobe not five cycles");
	a_write_hold: assert property (we && $past(we) |->
		$stable(flash_pins.addr) && $stable(flash_pins.dq_out) && flash_pins.dq_oe)
		else $error("address or data moved under write strobe");
	a_read_pulse: assert property ($rose(oe) |-> oe[*8] ##1 oe[*4] ##1 !oe)
		else $error("read strobe not twelve cycles");
	a_read_float: assert property (oe |-> !flash_pins.dq_oe)
		else $error("host drives data during read");
	a_strobe_sel: assert property (!flash_pins.we_n || !flash_pins.oe_n |-> !flash_pins.ce_n)
		else $error("strobe without chip select");
	a_strobe_excl: assert property (!(!flash_pins.we_n && !flash_pins.oe_n))
		else $error("write and read strobes together");
	a_write_recover: assert property ($fell(we) |-> (flash_pins.we_n && flash_pins.oe_n)[*3])
		else $error("recovery gap too short");
	a_rdata_slot: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
		else $error("read data outside its slot");
	c_write: cover property ($rose(we));
	c_read: cover property ($rose(oe));
	c_rdata: cover property (sw_rd ##1 sw_rdata != 32'h0);
endmodule
bind flash_protect_host flash_host_props i_flash_host_props (.mclk(mclk), .rst_n(rst_n),
	.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
	.sw_rdata(sw_rdata), .dq_in(dq_in), .flash_pins(flash_pins));

/* verif/flash_dev_model.sv */
// model: behavioural flash device facing the host pins
`timescale 1ns/100ps
module flash_dev_model
	import flash_cmd_pkg::*;
(
	input  wire logic        mclk,
	input  wire flash_pins_t pins,
	output logic [7:0]       dq_in
);
	logic [21:0] wa[$];
	logic [7:0]  wd[$];
	logic        persistent_protect_bit[128];
	logic        dynamic_protect_bit[128];
	logic [7:0]  mode; // 00 read, 90 autoselect, else set code
	logic [21:0] la;
	logic [7:0]  ld;
	logic        lacc;
	logic        last_we;
	logic [6:0]  s;
	logic [7:0]  r;
	int          acc_err;
	int          n;
	initial
	begin
		mode = 8'h00;
		last_we = 1'b1;
		dq_in = 8'h00;
		acc_err = 0;
		foreach (persistent_protect_bit[i]) persistent_protect_bit[i] = 1'b0;
		foreach (dynamic_protect_bit[i]) dynamic_protect_bit[i] = 1'b0;
	end
	// reads answer while selected; a released bus toggles so no stale value passes
	always @(posedge mclk)
	begin
		s = pins.addr[21:15];
		if (mode == code_autoselect && pins.addr[7:0] == 8'h04) r = {7'h00, persistent_protect_bit[s]};
		else if (mode == set_persistent) r = {7'h7f, !persistent_protect_bit[s]};
		else if (mode == set_dynamic) r = {7'h7f, !dynamic_protect_bit[s]};
		else r = pins.addr[7:0] ^ 8'h5a;
		dq_in <= (!pins.ce_n && !pins.oe_n) ? r : ~dq_in;
		if (!pins.we_n)
		begin
			la = pins.addr;
			ld = pins.dq_out;
			lacc = pins.acc;
		end
		// data taken as the write strobe rises
		if (!last_we && pins.we_n)
		begin
			wa.push_back(la);
			wd.push_back(ld);
			n = wd.size();
			s = la[21:15];
			if (mode == code_autoselect && ld == code_reset) mode = 8'h00;
			else if (n >= 3 && mode == 8'h00 && wd[n-3] == unlock_data_a && wd[n-2] == unlock_data_b
				&& wa[n-2][11:0] == unlock_addr_b && la[11:0] == unlock_addr_a
				&& ld inside {code_autoselect, set_lock_reg, set_password, set_persistent,
				set_freeze, set_dynamic}) mode = ld;
			else if (n >= 2 && mode != 8'h00 && mode != code_autoselect && wd[n-2] == code_exit_a
				&& ld == code_exit_b) mode = 8'h00;
			else if (n >= 2 && wd[n-2] == code_program && mode inside {set_persistent, set_dynamic})
			begin
				if (!lacc) acc_err++;
				if (ld == code_bit_set && mode == set_persistent) persistent_protect_bit[s] = 1'b1;
				if (ld == code_bit_set && mode == set_dynamic) dynamic_protect_bit[s] = 1'b1;
				if (ld == code_bit_clear && mode == set_dynamic) dynamic_protect_bit[s] = 1'b0;
			end
		end
		last_we <= pins.we_n;
	end
endmodule

/* verif/tb.sv */
// testbench: drives the flash protection host against the device model
`timescale 1ns/100ps
module tb
	import flash_cmd_pkg::*;
();
	typedef struct {op_t op; logic [7:0] setc; int n; logic [7:0] last;} row_t;
	localparam logic [21:0] addr_a = 22'h028104; // sector 5
	localparam logic [21:0] addr_b = 22'h048230; // sector 9
	logic        mclk;
	logic        rst_n;
	logic [3:0]  sw_addr;
	logic [31:0] sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [31:0] sw_rdata;
	logic [7:0]  dq_in;
	flash_pins_t flash_pins;
	int          mismatches;
	int          n_tests;
	int          cycles;
	int          n0;
	logic [31:0] v;
	row_t        rows[16];
	flash_protect_host i_flash_protect_host (.mclk(mclk), .rst_n(rst_n), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.dq_in(dq_in), .flash_pins(flash_pins));
	flash_dev_model i_flash_dev_model (.mclk(mclk), .pins(flash_pins), .dq_in(dq_in));
	// ****
	// clock and hang guard
	// ****
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
	begin
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	// ****
	// register port
	// ****
	task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
	begin
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	end
	endtask
	// data stand only in the cycle after the strobe
	task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
	begin
		@(posedge mclk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge mclk);
		sw_rd <= 1'b0;
		@(negedge mclk);
		d = sw_rdata;
	end
	endtask
	// issue one operation and poll busy; v keeps the final status
	task automatic run(input op_t op, input logic [7:0] setc, input logic [21:0] a);
		int k;
	begin
		sw_write(reg_addr, {10'h0, a});
		sw_write(reg_data, 32'h3c);
		n0 = i_flash_dev_model.wd.size();
		sw_write(reg_cmd, {16'h0, setc, 3'h0, op});
		k = 0;
		do
		begin
			sw_read(reg_status, v);
			k++;
		end
		while (v[0] !== 1'b0 && k < 500);
		if (k == 500) chk(v, 32'h0);
	end
	endtask
	task automatic stat(input logic [21:0] a, input logic e);
	begin
		run(op_status_read, 8'h00, a);
		sw_read(reg_rdata, v);
		chk(32'(v[0]), 32'(e));
	end
	endtask
	// ****
	// main sequence
	// ****
	initial
	begin
		rows = '{'{op_reset, 8'h00, 1, code_reset}, '{op_program, 8'h00, 4, 8'h3c},
			'{op_wbuf_abort, 8'h00, 3, code_reset},
			'{op_enter_set, set_lock_reg, 3, set_lock_reg}, '{op_exit_set, 8'h00, 2, 8'h00},
			'{op_enter_set, set_password, 3, set_password},
			'{op_pw_unlock, 8'h00, 11, code_wbuf_commit}, '{op_pw_program, 8'h00, 2, 8'h3c},
			'{op_exit_set, 8'h00, 2, 8'h00},
			'{op_enter_set, set_persistent, 3, set_persistent}, '{op_exit_set, 8'h00, 2, 8'h00},
			'{op_enter_set, set_freeze, 3, set_freeze}, '{op_set_write, 8'h00, 2, 8'h3c},
			'{op_exit_set, 8'h00, 2, 8'h00},
			'{op_enter_set, set_dynamic, 3, set_dynamic}, '{op_exit_set, 8'h00, 2, 8'h00}};
		rst_n = 1'b0;
		sw_addr = 4'h0;
		sw_wdata = 32'h0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		mismatches = 0;
		n_tests = 0;
		cycles = 0;
		repeat (5) @(posedge mclk);
		chk({flash_pins.ce_n, flash_pins.we_n, flash_pins.oe_n, flash_pins.dq_oe}, 32'he);
		chk(sw_rdata, 32'h0);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			run(rows[i].op, rows[i].setc, addr_a);
			chk(32'(i_flash_dev_model.wd.size() - n0), 32'(rows[i].n));
			chk(32'(i_flash_dev_model.wd[$]), 32'(rows[i].last));
			if (rows[i].op == op_enter_set) chk(32'(i_flash_dev_model.wa[n0][11:0]), 32'haaa);
			if (rows[i].op == op_pw_unlock) chk(32'(i_flash_dev_model.wa[n0]), 32'h0);
		end
		run(op_read, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd.size() - n0), 32'h0);
		sw_read(reg_rdata, v);
		chk(v, 32'(addr_a[7:0] ^ 8'h5a));
		sw_read(4'hf, v);
		chk(v, 32'h0);
		run(op_suspend, 8'h00, addr_a);
		chk(32'(v[2]), 32'h1);
		run(op_resume, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd.size() - n0), 32'h0);
		run(op_enter_set, set_persistent, addr_a);
		run(op_bit_set, 8'h00, addr_a);
		stat(addr_a, 1'b0);
		run(op_exit_set, 8'h00, addr_a);
		run(op_autoselect, 8'h00, addr_a);
		run(op_sect_verify, 8'h00, addr_a);
		sw_read(reg_rdata, v);
		chk(v, 32'h1);
		run(op_query, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd[$]), 32'(code_query));
		run(op_reset, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.mode), 32'h0);
		run(op_enter_set, set_dynamic, addr_b);
		run(op_bit_set, 8'h00, addr_b);
		stat(addr_b, 1'b0);
		stat(addr_a, 1'b1);
		run(op_bit_clear, 8'h00, addr_b);
		stat(addr_b, 1'b1);
		run(op_query, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd.size() - n0), 32'h0);
		run(op_exit_set, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.acc_err), 32'h0);
		run(op_erase_all, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wa[$]), 32'h0);
		run(op_pw_read, 8'h00, addr_a);
		sw_read(reg_pw_lo, v);
		chk(v, 32'h59585b5a);
		sw_write(reg_wbuf, 32'h5a);
		sw_write(reg_count, 32'h1);
		run(op_wbuf, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd.size() - n0), 32'h6);
		chk(32'(i_flash_dev_model.wd[n0 + 3]), 32'h0);
		chk(32'(i_flash_dev_model.wa[n0 + 4]), 32'(addr_a));
		run(op_sector_erase, 8'h00, addr_a);
		run(op_suspend, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd[$]), 32'(code_suspend));
		run(op_resume, 8'h00, addr_a);
		chk(32'(i_flash_dev_model.wd[$]), 32'(code_resume));
		print_verdict();
	end
endmodule
